/* File: rtl/rfs_pkg.sv */
// rfs_pkg: constants, register map and carrier types of the rail fault supervisor.
// assumes one 125 MHz system clock; analog comparators and the monitor reference live outside.
package rfs_pkg;

   // clock and timing
   localparam int CLK_MHZ = 125;
   localparam int FILT_US = 10;
   localparam int FILT_CYC = FILT_US * CLK_MHZ;
   localparam int PULSE_MS = 200;
   localparam int PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
   localparam int HICCUP_MS = 16;
   localparam int HICCUP_CYC = HICCUP_MS * 1000 * CLK_MHZ;
   localparam int FILT_W = 11;
   localparam int LONG_W = 25;

   // rails and power-ok pin groups
   localparam int RAILS = 4;
   localparam int GROUPS = 3;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_LOCKOUT = 8'h70;
   localparam logic [7:0] IDX_RAIL1 = 8'h72;
   localparam logic [7:0] IDX_RAIL2 = 8'h74;
   localparam logic [7:0] IDX_RAIL3 = 8'h76;
   localparam logic [7:0] IDX_RAIL4 = 8'h78;
   localparam logic [7:0] IDX_STATUS = 8'h80;
   localparam logic [7:0] IDX_MASK = 8'h81;
   localparam logic [7:0] IDX_LIVE = 8'h82;
   localparam int ADDR_W = 12;

   // field layout of a rail limit byte
   localparam int UV_LSB = 0;
   localparam int OV_LSB = 4;
   localparam int CODE_W = 4;

   // reset values of the programmed options
   localparam logic [7:0] LIMITS_RST = 8'h22;
   localparam logic [7:0] LOCKOUT_RST = 8'h00;
   localparam logic [1:0] RISE_CODE_RST = 2'h0;

   // threshold tables in percent of nominal, and lockout rising levels in tenths of a volt
   localparam logic [3:0][6:0] UV_PCT = {7'd88, 7'd92, 7'd94, 7'd96};
   localparam logic [3:0][6:0] OV_PCT = {7'd112, 7'd108, 7'd106, 7'd104};
   localparam logic [3:0][6:0] RISE_DV = {7'd70, 7'd65, 7'd50, 7'd45};
   localparam logic [6:0] FALL_DV = 7'd35;

   // status bit positions: uv[3:0], ov[7:4], oc[11:8], lockout drop [12]
   localparam int ST_UV = 0;
   localparam int ST_OV = 4;
   localparam int ST_OC = 8;
   localparam int ST_LOCK = 12;
   localparam int ST_W = 13;

   typedef enum logic [2:0] {
      RFS_SEL_LOCKOUT,
      RFS_SEL_LIMITS,
      RFS_SEL_STATUS,
      RFS_SEL_MASK,
      RFS_SEL_LIVE,
      RFS_SEL_NONE
   } rfs_sel_e;

   // asynchronous inputs that pass the two-stage synchroniser
   typedef struct packed {
      logic [RAILS-1:0] uv;
      logic [RAILS-1:0] ov;
      logic [RAILS-1:0] oc;
      logic vin_rise;
      logic vin_fall;
      logic [GROUPS-1:0] pg;
   } rfs_pin_s;

   // one-time-programmed options delivered by the option loader
   typedef struct packed {
      logic [7:0] lockout;
      logic [RAILS-1:0][7:0] limits;
      logic uv_filter;
   } rfs_otp_s;

   // APB slave request and answer
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } rfs_apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } rfs_apb_rsp_s;

endpackage

/* File: rtl/rfs_top.sv */
// rfs_top: fault supervision of four supply rails and the main input lockout, APB registers.
// assumes analog comparators feed uv/ov/oc and lockout levels asynchronously, and an
// option loader on clk_sys presents the programmed options with a one-cycle valid.
//
// Notes on behaviour
// - per-rail limit byte, uv low, ov high
// - uv codes give 96, 94, 92, 88 percent
// - ov codes give 104, 106, 108, 112 percent
// - unprogrammed rails use code 2 both
// - uv fault, optional shared 10us filter
// - switcher overvoltage tri-states switches at once
// - ov fault only after 10us continuous
// - any uv or ov fault pulls power-ok low 200ms; overcurrent alone does not
// - overcurrent-caused uv asserts fault reset
// - low rails keep regulating on uv; ov tri-states their switches
// - overcurrent disables rail with hiccup restart
// - lockout rising 4.5/5.0/6.5/7.0V, falling 3.5V
// - no power-up before rising threshold crossed
// - default 4.5V rising until options loaded
// - monitor thresholds from separate reference
`timescale 1ns/1ps
`default_nettype none

module rfs_top #(
   parameter int PULSE_CYCLES = rfs_pkg::PULSE_CYC,
   parameter int HICCUP_CYCLES = rfs_pkg::HICCUP_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // apb slave
   input wire rfs_pkg::rfs_apb_req_s apb_req,
   output rfs_pkg::rfs_apb_rsp_s apb_rsp,
   // programmed options from the loader
   input wire logic otp_valid,
   input wire rfs_pkg::rfs_otp_s otp,
   // analog comparator results and open-drain pin levels
   input wire rfs_pkg::rfs_pin_s pins_async,
   // thresholds to the monitor reference: uv/ov in percent of nominal, lockout rising level as a 2-bit code
   output logic [rfs_pkg::RAILS-1:0][6:0] uv_limit_pct,
   output logic [rfs_pkg::RAILS-1:0][6:0] ov_limit_pct,
   output logic [1:0] lockout_rise_code,
   // power stage control
   output logic [2:0] switch_hiz,
   output logic [rfs_pkg::RAILS-1:0] rail_disable,
   output logic power_up_ok,
   // open-drain power-ok pins, enable low while pulling low
   output logic rail1_power_ok_o,
   output logic rail1_power_ok_oe_n,
   output logic low_rails_power_ok_o,
   output logic low_rails_power_ok_oe_n,
   output logic linear_rail_power_ok_o,
   output logic linear_rail_power_ok_oe_n,
   // reset to the system controller and interrupt
   output logic fault_reset_n,
   output logic irq
);
   import rfs_pkg::*;

   typedef struct packed {
      rfs_pin_s meta;
      rfs_pin_s sync;
      logic [RAILS-1:0][FILT_W-1:0] uv_cnt;
      logic [RAILS-1:0][FILT_W-1:0] ov_cnt;
      logic [RAILS-1:0] uv_flt;
      logic [RAILS-1:0] ov_flt;
      logic [RAILS-1:0] oc_q;
      logic [GROUPS-1:0][LONG_W-1:0] pg_cnt;
      logic [GROUPS-1:0] pg_low;
      logic [LONG_W-1:0] rst_cnt;
      logic rst_low;
      logic [RAILS-1:0][LONG_W-1:0] hic_cnt;
      logic [RAILS-1:0] hic_on;
      logic lock_ok;
      logic init_done;
      logic [7:0] lockout;
      logic [RAILS-1:0][7:0] limits;
      logic uv_filter;
      logic [RAILS-1:0][6:0] uv_pct;
      logic [RAILS-1:0][6:0] ov_pct;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      logic [31:0] prdata;
      logic pslverr;
   } rfs_state_s;

   localparam logic [FILT_W-1:0] FILT_N = FILT_W'(FILT_CYC);
   localparam logic [LONG_W-1:0] PULSE_N = LONG_W'(PULSE_CYCLES);
   localparam logic [LONG_W-1:0] HICCUP_N = LONG_W'(HICCUP_CYCLES);

   rfs_state_s st_reg;
   rfs_state_s st_next;

   // address decode shared by read and write
   function automatic rfs_sel_e reg_sel(input logic [ADDR_W-1:0] addr);
      logic [7:0] idx;
      idx = addr[9:2];
      if (addr[1:0] != 2'h0 || addr[ADDR_W-1:10] != '0)
         reg_sel = RFS_SEL_NONE;
      else if (idx == IDX_LOCKOUT)
         reg_sel = RFS_SEL_LOCKOUT;
      else if (idx == IDX_RAIL1 || idx == IDX_RAIL2 || idx == IDX_RAIL3 || idx == IDX_RAIL4)
         reg_sel = RFS_SEL_LIMITS;
      else if (idx == IDX_STATUS)
         reg_sel = RFS_SEL_STATUS;
      else if (idx == IDX_MASK)
         reg_sel = RFS_SEL_MASK;
      else if (idx == IDX_LIVE)
         reg_sel = RFS_SEL_LIVE;
      else
         reg_sel = RFS_SEL_NONE;
   endfunction

   // rail to power-ok pin group: rail1, rails 2 and 3 shared, linear rail
   function automatic int rail_group(input int r);
      if (r == 0)
         rail_group = 0;
      else if (r == RAILS - 1)
         rail_group = 2;
      else
         rail_group = 1;
   endfunction

   // next-state logic of the whole block
   always_comb
   begin
      logic [GROUPS-1:0] grp_fault;
      logic [GROUPS-1:0] grp_event;
      logic [ST_W-1:0] events;
      logic [ST_W-1:0] w1c;
      logic [7:0] ridx;
      rfs_sel_e sel;
      logic setup;
      logic access;
      grp_fault = '0;
      grp_event = '0;
      events = '0;
      w1c = '0;
      st_next = st_reg;
      setup = apb_req.psel && !apb_req.penable;
      access = apb_req.psel && apb_req.penable;
      sel = reg_sel(apb_req.paddr);
      ridx = apb_req.paddr[9:2];

      // two-stage synchroniser for every asynchronous input
      st_next.meta = pins_async;
      st_next.sync = st_reg.meta;
      st_next.oc_q = st_reg.sync.oc;

      // capture programmed options once the loader is done
      // default rising level until loaded
      if (otp_valid)
      begin
         st_next.lockout = otp.lockout;
         st_next.limits = otp.limits;
         st_next.uv_filter = otp.uv_filter;
         st_next.init_done = 1'b1;
      end

      for (int r = 0; r < RAILS; r++)
      begin
         // uv code low nibble, ov high
         st_next.uv_pct[r] = UV_PCT[st_reg.limits[r][UV_LSB +: 2]];
         st_next.ov_pct[r] = OV_PCT[st_reg.limits[r][OV_LSB +: 2]];

         if (!st_reg.sync.uv[r])
            st_next.uv_cnt[r] = '0;
         else if (st_reg.uv_cnt[r] != FILT_N)
            st_next.uv_cnt[r] = st_reg.uv_cnt[r] + FILT_W'(1);
         st_next.uv_flt[r] = st_reg.sync.uv[r] &&
            (!st_reg.uv_filter || st_next.uv_cnt[r] == FILT_N);

         if (!st_reg.sync.ov[r])
            st_next.ov_cnt[r] = '0;
         else if (st_reg.ov_cnt[r] != FILT_N)
            st_next.ov_cnt[r] = st_reg.ov_cnt[r] + FILT_W'(1);
         st_next.ov_flt[r] = st_reg.sync.ov[r] && st_next.ov_cnt[r] == FILT_N;

         // collect fault levels and new fault edges per pin group
         if (st_reg.uv_flt[r] || st_reg.ov_flt[r])
            grp_fault[rail_group(r)] = 1'b1;
         if ((st_next.uv_flt[r] && !st_reg.uv_flt[r]) ||
             (st_next.ov_flt[r] && !st_reg.ov_flt[r]))
            grp_event[rail_group(r)] = 1'b1;

         events[ST_UV + r] = st_next.uv_flt[r] && !st_reg.uv_flt[r];
         events[ST_OV + r] = st_next.ov_flt[r] && !st_reg.ov_flt[r];
         events[ST_OC + r] = st_reg.sync.oc[r] && !st_reg.oc_q[r];

         if (events[ST_UV + r] && st_reg.sync.oc[r])
            st_next.rst_cnt = PULSE_N;

         // plain uv/ov never disables a rail
         if (events[ST_OC + r])
            st_next.hic_cnt[r] = HICCUP_N;
         else if (st_reg.hic_cnt[r] != '0)
            st_next.hic_cnt[r] = st_reg.hic_cnt[r] - LONG_W'(1);
         st_next.hic_on[r] = st_next.hic_cnt[r] != '0;
      end

      // fault reset pulse countdown
      if (st_next.rst_cnt == st_reg.rst_cnt && st_reg.rst_cnt != '0)
         st_next.rst_cnt = st_reg.rst_cnt - LONG_W'(1);
      st_next.rst_low = st_next.rst_cnt != '0;

      for (int g = 0; g < GROUPS; g++)
      begin
         // fault edge starts a 200ms low pulse
         if (grp_event[g])
            st_next.pg_cnt[g] = PULSE_N;
         else if (st_reg.pg_cnt[g] != '0)
            st_next.pg_cnt[g] = st_reg.pg_cnt[g] - LONG_W'(1);
         st_next.pg_low[g] = st_next.pg_cnt[g] != '0 || grp_fault[g];
      end

      if (st_reg.sync.vin_fall)
         st_next.lock_ok = 1'b0;
      else if (st_reg.sync.vin_rise)
         st_next.lock_ok = 1'b1;
      events[ST_LOCK] = st_reg.lock_ok && !st_next.lock_ok;

      // write-one-to-clear status and mask writes, taken in the access phase
      if (access && apb_req.pwrite)
      begin
         if (sel == RFS_SEL_STATUS)
            w1c = apb_req.pwdata[ST_W-1:0];
         if (sel == RFS_SEL_MASK)
            st_next.mask = apb_req.pwdata[ST_W-1:0];
      end
      // a new event wins over a clear in the same cycle
      st_next.status = (st_reg.status & ~w1c) | events;

      // read data and error prepared in the setup phase
      if (setup)
      begin
         st_next.prdata = '0;
         st_next.pslverr = 1'b0;
         unique case (sel)
            RFS_SEL_LOCKOUT:
               st_next.prdata[7:0] = st_reg.lockout;
            RFS_SEL_LIMITS:
               st_next.prdata[7:0] = st_reg.limits[2'((ridx - IDX_RAIL1) >> 1)];
            RFS_SEL_STATUS:
               st_next.prdata[ST_W-1:0] = st_reg.status;
            RFS_SEL_MASK:
               st_next.prdata[ST_W-1:0] = st_reg.mask;
            RFS_SEL_LIVE:
               st_next.prdata[25:0] = {st_reg.lock_ok, st_reg.init_done, st_reg.rst_low,
                  st_reg.sync.pg, st_reg.pg_low, st_reg.hic_on, st_reg.sync.oc,
                  st_reg.ov_flt, st_reg.uv_flt};
            RFS_SEL_NONE:
               st_next.pslverr = apb_req.pwrite || 1'b1;
         endcase
         // read-only option registers refuse writes
         if (apb_req.pwrite && (sel == RFS_SEL_LOCKOUT || sel == RFS_SEL_LIMITS ||
             sel == RFS_SEL_LIVE))
            st_next.pslverr = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
         st_reg.limits <= {RAILS{LIMITS_RST}};
         st_reg.lockout <= LOCKOUT_RST;
         st_reg.uv_pct <= {RAILS{UV_PCT[2]}};
         st_reg.ov_pct <= {RAILS{OV_PCT[2]}};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // apb answer: zero wait states
   assign apb_rsp.pready = apb_req.psel && apb_req.penable;
   assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && st_reg.pslverr;
   assign apb_rsp.prdata = st_reg.prdata;

   // thresholds to the separate monitor reference
   assign uv_limit_pct = st_reg.uv_pct;
   assign ov_limit_pct = st_reg.ov_pct;
   assign lockout_rise_code = st_reg.init_done ? st_reg.lockout[1:0] : RISE_CODE_RST;

   // switcher ov tri-states switches at once
   assign switch_hiz = st_reg.sync.ov[2:0];
   assign rail_disable = st_reg.hic_on;
   assign power_up_ok = st_reg.lock_ok;

   // open-drain power-ok pins only ever pull low
   assign rail1_power_ok_o = 1'b0;
   assign rail1_power_ok_oe_n = !st_reg.pg_low[0];
   assign low_rails_power_ok_o = 1'b0;
   assign low_rails_power_ok_oe_n = !st_reg.pg_low[1];
   assign linear_rail_power_ok_o = 1'b0;
   assign linear_rail_power_ok_oe_n = !st_reg.pg_low[2];

   assign fault_reset_n = !st_reg.rst_low;
   assign irq = |(st_reg.status & st_reg.mask);

endmodule

`default_nettype wire

/* File: test/rfs_top_properties.sv */
// rfs_top_chk: port timing properties of the rail fault supervisor.
// assumes binding onto rfs_top; pulse length handed on from the instance.
`timescale 1ns/1ps
`default_nettype none
module rfs_top_chk #(
   parameter int PULSE_CYCLES = 50,
   parameter int HICCUP_CYCLES = 40
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // inputs watched
   input wire logic otp_valid,
   input wire rfs_pkg::rfs_otp_s otp,
   input wire rfs_pkg::rfs_pin_s pins_async,
   // outputs watched
   input wire logic [rfs_pkg::RAILS-1:0][6:0] uv_limit_pct,
   input wire logic [rfs_pkg::RAILS-1:0][6:0] ov_limit_pct,
   input wire logic [1:0] lockout_rise_code,
   input wire logic [2:0] switch_hiz,
   input wire logic [rfs_pkg::RAILS-1:0] rail_disable,
   input wire logic rail1_power_ok_oe_n,
   input wire logic fault_reset_n
);
   import rfs_pkg::*;
   int ov_run;
   int lo_run;
   int oc_age;
   logic seen;
   logic [1:0] code;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // run lengths, overcurrent age and the loaded lockout code
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ov_run <= 0;
         lo_run <= 0;
         oc_age <= 99;
         seen <= 1'b0;
         code <= 2'h0;
      end
      else
      begin
         ov_run <= pins_async.ov[0] ? (ov_run < 5000 ? ov_run + 1 : ov_run) : 0;
         lo_run <= rail1_power_ok_oe_n ? 0 : lo_run + 1;
         oc_age <= (|pins_async.oc) ? 0 : (oc_age < 99 ? oc_age + 1 : oc_age);
         seen <= seen | otp_valid;
         code <= otp_valid ? otp.lockout[1:0] : code;
      end
   end
   a_ov_hiz_fast: assert property ($rose(pins_async.ov[0]) |-> ##[1:3] switch_hiz[0])
      else $error("switch tri-state late");
   a_hiz_clear: assert property (!pins_async.ov[0] [*4] |-> !switch_hiz[0])
      else $error("switch tri-state without overvoltage");
   a_ov_filter: assert property ($fell(rail1_power_ok_oe_n) |->
      $past(ov_run, 3) >= 1248 || pins_async.uv[0] || $past(pins_async.uv[0], 4))
      else $error("power ok dropped before filter time");
   a_ov_late: assert property (ov_run == 1270 |-> !rail1_power_ok_oe_n)
      else $error("overvoltage not flagged");
   a_pulse_min: assert property ($rose(rail1_power_ok_oe_n) |-> lo_run >= PULSE_CYCLES)
      else $error("power ok pulse too short");
   a_oc_reset: assert property ($rose(pins_async.uv[1]) && pins_async.oc[1]
      |-> ##[2:6] !fault_reset_n)
      else $error("fault reset missing");
   a_reset_cause: assert property ($fell(fault_reset_n) |-> oc_age < 8)
      else $error("fault reset without overcurrent");
   a_oc_hiccup: assert property ($rose(pins_async.oc[1]) |-> ##[2:6] rail_disable[1])
      else $error("rail not disabled on overcurrent");
   a_lock_default: assert property (!seen |-> lockout_rise_code == 2'h0
      && uv_limit_pct[0] == 7'd92 && ov_limit_pct[0] == 7'd108)
      else $error("defaults wrong before load");
   a_lock_code: assert property ($past(otp_valid, 3) |-> lockout_rise_code == code)
      else $error("lockout code not taken");
   c_pulse: cover property ($rose(rail1_power_ok_oe_n));
   c_reset: cover property ($fell(fault_reset_n));
   c_hiccup: cover property ($rose(rail_disable[1]));
endmodule
bind rfs_top rfs_top_chk #(.PULSE_CYCLES(PULSE_CYCLES), .HICCUP_CYCLES(HICCUP_CYCLES)) u_chk (
   .clk_sys, .rst_n, .otp_valid, .otp, .pins_async, .uv_limit_pct, .ov_limit_pct,
   .lockout_rise_code, .switch_hiz, .rail_disable, .rail1_power_ok_oe_n, .fault_reset_n);
`default_nettype wire

/* File: test/rfs_sys_ctrl.sv */
// rfs_sys_ctrl: system controller side of the power-ok and reset lines.
// assumes pull-ups on the three power-ok wires.
`timescale 1ns/1ps
`default_nettype none
module rfs_sys_ctrl (
   // drivers from the supervisor
   input wire logic [2:0] pg_o,
   input wire logic [2:0] pg_oe_n,
   input wire logic fault_reset_n,
   // resolved wires and reset count
   output logic [2:0] pg_wire,
   output var int resets_seen
);
   // pull-up wins while no driver is enabled
   assign pg_wire = pg_o | pg_oe_n;
   // count reset pulses seen
   initial resets_seen = 0;
   always @(negedge fault_reset_n) resets_seen <= resets_seen + 1;
endmodule
`default_nettype wire

/* File: test/tb.sv */
// tb: register and fault sequences for the rail fault supervisor.
// assumes a 50-cycle power-ok pulse and a 40-cycle hiccup in simulation.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rfs_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   rfs_apb_req_s req = '0;
   rfs_apb_rsp_s rsp;
   logic otp_valid = 1'b0;
   rfs_otp_s otp = '0;
   rfs_pin_s drv = '0;
   wire rfs_pin_s pins;
   wire [2:0] pg_o;
   wire [2:0] pg_oe_n;
   logic [2:0] pg_wire;
   logic [RAILS-1:0][6:0] uv_pct;
   logic [RAILS-1:0][6:0] ov_pct;
   logic [1:0] rise;
   logic [2:0] hiz;
   logic [RAILS-1:0] dis;
   logic pwr_ok;
   logic frst_n;
   logic irq;
   int resets_seen;
   int num_errors = 0;
   int checked = 0;
   logic [31:0] rd;
   logic err;
   always #4 clk_sys = ~clk_sys;
   assign pins = {drv.uv, drv.ov, drv.oc, drv.vin_rise, drv.vin_fall, pg_wire};
   rfs_top #(.PULSE_CYCLES(50), .HICCUP_CYCLES(40)) dut (
      .clk_sys, .rst_n, .apb_req(req), .apb_rsp(rsp), .otp_valid, .otp, .pins_async(pins),
      .uv_limit_pct(uv_pct), .ov_limit_pct(ov_pct), .lockout_rise_code(rise),
      .switch_hiz(hiz), .rail_disable(dis), .power_up_ok(pwr_ok),
      .rail1_power_ok_o(pg_o[0]), .rail1_power_ok_oe_n(pg_oe_n[0]),
      .low_rails_power_ok_o(pg_o[1]), .low_rails_power_ok_oe_n(pg_oe_n[1]),
      .linear_rail_power_ok_o(pg_o[2]), .linear_rail_power_ok_oe_n(pg_oe_n[2]),
      .fault_reset_n(frst_n), .irq);
   rfs_sys_ctrl u_ctrl (.pg_o, .pg_oe_n, .fault_reset_n(frst_n), .pg_wire, .resets_seen);
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (rsp.pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         num_errors++;
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
      begin
         $display("Testbench passed");
      end
      else
      begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // main sequence
   initial
   begin
      cyc(3);
      rst_n <= 1'b1;
      apb(1'b0, 12'h1C0, 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, 12'h1C8 + 12'(8 * i), 32'h0);
         chk(rd, 32'h22);
         chk(32'({uv_pct[i], ov_pct[i]}), 32'({7'd92, 7'd108}));
      end
      apb(1'b0, 12'h300, 32'h0);
      chk(32'(err), 32'h1);
      apb(1'b1, 12'h204, 32'h1FFF);
      apb(1'b0, 12'h204, 32'h0);
      chk(rd, 32'h1FFF);
      chk(32'(rise), 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         otp.limits[i] <= {4'(3 - i), 4'(i)};
      end
      otp.lockout <= 8'h03;
      otp_valid <= 1'b1;
      cyc(1);
      otp_valid <= 1'b0;
      cyc(4);
      chk(32'(rise), 32'h3);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, 12'h1C8 + 12'(8 * i), 32'h0);
         chk(rd, 32'({4'(3 - i), 4'(i)}));
         chk(32'(uv_pct[i]), 32'(UV_PCT[i]));
         chk(32'(ov_pct[i]), 32'(OV_PCT[3 - i]));
      end
      apb(1'b1, 12'h1C0, 32'hFF);
      chk(32'(err), 32'h1);
      chk(32'(pwr_ok), 32'h0);
      drv.vin_rise <= 1'b1;
      cyc(6);
      chk(32'(pwr_ok), 32'h1);
      drv.vin_rise <= 1'b0;
      cyc(6);
      chk(32'(pwr_ok), 32'h1);
      // rail1 overvoltage: glitch, then a long excursion
      drv.ov[0] <= 1'b1;
      cyc(5);
      chk(32'(hiz[0]), 32'h1);
      cyc(1000);
      chk(32'(pg_wire[0]), 32'h1);
      drv.ov[0] <= 1'b0;
      cyc(10);
      drv.ov[0] <= 1'b1;
      cyc(1320);
      chk(32'({pg_wire[0], irq}), 32'h1);
      cyc(80);
      chk(32'(pg_wire[0]), 32'h0);
      drv.ov[0] <= 1'b0;
      cyc(10);
      chk(32'(pg_wire[0]), 32'h1);
      apb(1'b0, 12'h200, 32'h0);
      chk(rd, 32'h10);
      apb(1'b1, 12'h200, 32'h1FFF);
      cyc(1);
      chk(32'(irq), 32'h0);
      // short low-rail undervoltage, then overcurrent on rail2
      drv.uv[2] <= 1'b1;
      cyc(5);
      drv.uv[2] <= 1'b0;
      cyc(30);
      chk(32'({pg_wire[1], dis[2], frst_n}), 32'h1);
      cyc(40);
      chk(32'(pg_wire[1]), 32'h1);
      drv.oc[1] <= 1'b1;
      drv.uv[1] <= 1'b1;
      cyc(8);
      chk(32'({frst_n, dis[1]}), 32'h1);
      drv.oc[1] <= 1'b0;
      drv.uv[1] <= 1'b0;
      cyc(60);
      chk(32'({frst_n, dis[1], pg_wire[1]}), 32'h5);
      chk(32'(resets_seen), 32'h1);
      apb(1'b0, 12'h200, 32'h0);
      chk(rd, 32'h206);
      // shared uv filter on: a short dip is rejected, a long one is flagged
      otp.uv_filter <= 1'b1;
      otp_valid <= 1'b1;
      cyc(1);
      otp_valid <= 1'b0;
      drv.uv[3] <= 1'b1;
      cyc(100);
      drv.uv[3] <= 1'b0;
      cyc(10);
      chk(32'(pg_wire[2]), 32'h1);
      drv.uv[3] <= 1'b1;
      cyc(1300);
      chk(32'(pg_wire[2]), 32'h0);
      drv.uv[3] <= 1'b0;
      cyc(60);
      chk(32'(pg_wire[2]), 32'h1);
      drv.vin_fall <= 1'b1;
      cyc(6);
      chk(32'(pwr_ok), 32'h0);
      apb(1'b0, 12'h200, 32'h0);
      chk(32'(rd[12]), 32'h1);
      wrap_up;
   end
   // watchdog
   initial
   begin
      #160000;
      num_errors++;
      wrap_up;
   end
endmodule
`default_nettype wire
